// [design/ima_indirect.sv]
// Indirect addressing front end of the core's data memory.
// Assumes the core presents one access per valid cycle; its bank select is a plain level.
`timescale 1ns/1ps
module ima_indirect #(
    parameter int NUM_BANKS = ima_pkg::IMA_NUM_BANKS,
    parameter int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Core operand access
    input wire logic core_req_valid,
    input wire ima_pkg::ima_req_t core_req,
    input wire logic [BANK_W-1:0] core_bank,
    // Read answer
    output ima_pkg::ima_rsp_t core_rsp
);
    import ima_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address classification, used for both direct and pointer targets
    function automatic ima_kind_t ima_kind(input logic [IMA_ADDR_W-1:0] a);
        ima_kind_t k;
        if (a == IMA_PORT_ZERO_ADDR)
            k = IMA_KIND_PORT0;
        else if (a == IMA_PORT_ONE_ADDR)
            k = IMA_KIND_PORT1;
        else if (a == IMA_PTR_ZERO_ADDR)
            k = IMA_KIND_PTR0;
        else if (a == IMA_PTR_ONE_ADDR)
            k = IMA_KIND_PTR1;
        else if (a >= IMA_GP_BASE)
            k = IMA_KIND_GP;
        else
            k = IMA_KIND_SPARE;
        return k;
    endfunction : ima_kind

    logic [IMA_DATA_W-1:0] ptr0_ff, nxt_ptr0;
    logic [IMA_DATA_W-1:0] ptr1_ff, nxt_ptr1;
    ima_rsp_t rsp_ff, nxt_rsp;

    ima_kind_t dir_kind;
    ima_kind_t eff_kind;
    logic indirect;
    logic [IMA_ADDR_W-1:0] tgt_addr;
    logic [BANK_W-1:0] tgt_bank;
    logic ram_we;
    logic [IMA_ADDR_W-1:0] ram_ofs;
    logic [IMA_DATA_W-1:0] ram_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Target resolution
    always_comb
    begin
        dir_kind = ima_kind(core_req.addr);
        indirect = 1'b0;
        tgt_addr = core_req.addr;
        tgt_bank = core_bank;
        if (dir_kind == IMA_KIND_PORT0)
        begin
            indirect = 1'b1;
            tgt_addr = ptr0_ff;
            tgt_bank = '0;
        end
        else if (dir_kind == IMA_KIND_PORT1)
        begin
            indirect = 1'b1;
            tgt_addr = ptr1_ff;
            tgt_bank = core_bank;
        end
        // A port reached through a pointer resolves to nothing, so a self-loop cannot recurse
        eff_kind = indirect ? ima_kind(tgt_addr) : dir_kind;
        ram_we = core_req_valid && core_req.we && (eff_kind == IMA_KIND_GP);
        ram_ofs = tgt_addr - IMA_GP_BASE;
    end

    ima_bank_ram #(
        .DATA_W(IMA_DATA_W),
        .NUM_BANKS(NUM_BANKS),
        .WORDS(IMA_GP_WORDS),
        .BANK_W(BANK_W),
        .OFS_W(IMA_ADDR_W)
    ) u_ram (
        .core_clk(core_clk),
        .wr_en(ram_we),
        .bank(tgt_bank),
        .ofs(ram_ofs),
        .wdata(core_req.wdata),
        .rdata(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pointer storage and read answer
    always_comb
    begin
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_rsp.valid = core_req_valid && !core_req.we;
        nxt_rsp.data = rsp_ff.data;
        if (core_req_valid && core_req.we)
        begin
            // Ports and spare locations take no write at all
            if (eff_kind == IMA_KIND_PTR0)
                nxt_ptr0 = core_req.wdata;
            else if (eff_kind == IMA_KIND_PTR1)
                nxt_ptr1 = core_req.wdata;
        end
        else if (core_req_valid)
        begin
            case (eff_kind)
                IMA_KIND_GP: nxt_rsp.data = ram_rdata;
                IMA_KIND_PTR0: nxt_rsp.data = ptr0_ff;
                IMA_KIND_PTR1: nxt_rsp.data = ptr1_ff;
                IMA_KIND_SPARE: nxt_rsp.data = IMA_READ_ZERO;
                default: nxt_rsp.data = IMA_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ptr0_ff <= IMA_PTR_RST;
            ptr1_ff <= IMA_PTR_RST;
            rsp_ff <= '0;
        end
        else
        begin
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
            rsp_ff <= nxt_rsp;
        end
    end

    assign core_rsp = rsp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    logic rd_req, wr_req;
    assign rd_req = core_req_valid && !core_req.we;
    assign wr_req = core_req_valid && core_req.we;

    a_self_read_zero: assert property (
        (rd_req && indirect && (eff_kind == IMA_KIND_PORT0 || eff_kind == IMA_KIND_PORT1))
        |=> (core_rsp.valid && core_rsp.data == IMA_READ_ZERO))
        else $error("indirect read of a port did not return zero");

    a_self_write_none: assert property (
        (wr_req && indirect && (eff_kind == IMA_KIND_PORT0 || eff_kind == IMA_KIND_PORT1))
        |-> (!ram_we ##1 (ptr0_ff == $past(ptr0_ff) && ptr1_ff == $past(ptr1_ff))))
        else $error("indirect write of a port changed state");

    // A write through port one that lands nowhere must not be readable back through the same port
    a_port_no_store: assert property (
        (wr_req && dir_kind == IMA_KIND_PORT1 && eff_kind != IMA_KIND_GP
            && eff_kind != IMA_KIND_PTR0 && eff_kind != IMA_KIND_PTR1)
        ##1 (rd_req && dir_kind == IMA_KIND_PORT1 && $stable(ptr1_ff))
        |=> core_rsp.data == IMA_READ_ZERO)
        else $error("a port location held data");

    a_port_zero_bank: assert property (
        (core_req_valid && dir_kind == IMA_KIND_PORT0) |-> (tgt_bank == '0 && tgt_addr == ptr0_ff))
        else $error("port zero left bank 0");

    a_port_one_bank: assert property (
        (core_req_valid && dir_kind == IMA_KIND_PORT1) |-> (tgt_bank == core_bank && tgt_addr == ptr1_ff))
        else $error("port one ignored the selected bank");

    a_indirect_write: assert property (
        (wr_req && dir_kind == IMA_KIND_PORT1 && ptr1_ff >= IMA_GP_BASE)
        |-> (ram_we && ram_ofs == ptr1_ff - IMA_GP_BASE))
        else $error("indirect write missed the pointed location");

    a_ptr_write_read: assert property (
        (wr_req && !indirect && dir_kind == IMA_KIND_PTR0)
        ##1 (rd_req && !indirect && dir_kind == IMA_KIND_PTR0)
        |=> core_rsp.data == $past(core_req.wdata, 2))
        else $error("pointer zero did not hold the written value");

    a_spare_ignored: assert property (
        (wr_req && !indirect && dir_kind == IMA_KIND_SPARE)
        |=> (ptr0_ff == $past(ptr0_ff) && ptr1_ff == $past(ptr1_ff)))
        else $error("write to unused location changed state");

    a_rsp_timing: assert property (
        core_rsp.valid == $past(rd_req))
        else $error("read answer not one cycle after the request");

    c_indirect_gp_read: cover property (rd_req && indirect && eff_kind == IMA_KIND_GP);
    c_self_loop: cover property (wr_req && indirect && eff_kind == IMA_KIND_PORT1);
    c_ptr_via_port: cover property (rd_req && indirect && eff_kind == IMA_KIND_PTR0);

endmodule : ima_indirect

// [include/ima_pkg.sv]
// Constants and carrier types for the indirect data memory access block.
// Assumes one processor core on core_clk issuing at most one operand access per cycle.
// Functional notes
// - The two indirect port locations own no storage; they only redirect accesses.
// - Port accesses act on the data memory location named by the matching pointer.
// - Port zero with pointer zero reaches bank 0 only, whatever bank is selected.
// - Port one with pointer one reaches any bank through the selected bank.
// - Reading an indirect port through indirection returns 00H.
// - Writing an indirect port through indirection is discarded, no state changes.
// - Both pointers are real storage, readable, writable and modifiable directly.
package ima_pkg;

    localparam int IMA_DATA_W = 8;
    localparam int IMA_ADDR_W = 8;
    localparam int IMA_NUM_BANKS = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Special area map, shared by all banks
    localparam logic [IMA_ADDR_W-1:0] IMA_PORT_ZERO_ADDR = 8'h00;
    localparam logic [IMA_ADDR_W-1:0] IMA_PTR_ZERO_ADDR = 8'h01;
    localparam logic [IMA_ADDR_W-1:0] IMA_PORT_ONE_ADDR = 8'h02;
    localparam logic [IMA_ADDR_W-1:0] IMA_PTR_ONE_ADDR = 8'h03;
    // General purpose area is banked from here to the top of the address space
    localparam logic [IMA_ADDR_W-1:0] IMA_GP_BASE = 8'h40;
    localparam int IMA_GP_WORDS = 192;

    ////////////////////////////////////////////////////////////////////////////
    // Reset and fixed values
    localparam logic [IMA_DATA_W-1:0] IMA_PTR_RST = 8'h00;
    localparam logic [IMA_DATA_W-1:0] IMA_READ_ZERO = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic we;
        logic [IMA_ADDR_W-1:0] addr;
        logic [IMA_DATA_W-1:0] wdata;
    } ima_req_t;

    typedef struct packed {
        logic valid;
        logic [IMA_DATA_W-1:0] data;
    } ima_rsp_t;

    typedef enum logic [2:0] {
        IMA_KIND_PORT0 = 3'h0,
        IMA_KIND_PORT1 = 3'h1,
        IMA_KIND_PTR0 = 3'h2,
        IMA_KIND_PTR1 = 3'h3,
        IMA_KIND_SPARE = 3'h4,
        IMA_KIND_GP = 3'h5
    } ima_kind_t;

endpackage : ima_pkg

// [design/ima_bank_ram.sv]
// Banked general purpose data memory built from flip-flops.
// Assumes the caller keeps the offset below WORDS; read is combinational.
`timescale 1ns/1ps
module ima_bank_ram #(
    parameter int DATA_W = 8,
    parameter int NUM_BANKS = 2,
    parameter int WORDS = 192,
    parameter int BANK_W = 1,
    parameter int OFS_W = 8
) (
    // Clock
    input wire logic core_clk,
    // Access
    input wire logic wr_en,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [OFS_W-1:0] ofs,
    input wire logic [DATA_W-1:0] wdata,
    output logic [DATA_W-1:0] rdata
);
    localparam int DEPTH = NUM_BANKS * WORDS;
    localparam int IDX_W = $clog2(DEPTH);

    logic [DATA_W-1:0] mem_ff [DEPTH];
    logic [IDX_W-1:0] idx;

    // Contents are left uninitialised, as data memory is after power up
    always_comb
    begin
        idx = IDX_W'(32'(bank) * WORDS + 32'(ofs));
        rdata = mem_ff[idx];
    end

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem_ff[idx] <= wdata;
        end
    end

endmodule : ima_bank_ram

// [bench/ima_core_model.sv]
// Behavioural processor core issuing one operand access per call.
// Assumes the bench calls access and idle from a single thread.
`timescale 1ns/1ps
module ima_core_model (
    // Clock
    input wire logic core_clk,
    // Access towards the block
    output logic core_req_valid,
    output ima_pkg::ima_req_t core_req,
    output logic [0:0] core_bank
);
    import ima_pkg::*;

    initial
    begin
        core_req_valid = 1'b0;
        core_req = '0;
        core_bank = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request and qualifiers change only just after a falling edge
    task automatic access(input logic we, input logic [7:0] a, input logic b, input logic [7:0] d);
        @(negedge core_clk);
        core_req_valid = 1'b1;
        core_req.we = we;
        core_req.addr = a;
        core_req.wdata = d;
        core_bank = b;
    endtask : access

    // Released lines show the inverse of the last value, so nothing stale passes
    task automatic idle();
        @(negedge core_clk);
        core_req_valid = 1'b0;
        core_req = ~core_req;
        core_bank = ~core_bank;
    endtask : idle
endmodule : ima_core_model

// [bench/tb_top.sv]
// Self-checking bench for the indirect access front end, with a reference model.
// Assumes the core model drives every request input of the block.
`timescale 1ns/1ps
module tb_top;
    import ima_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic core_req_valid;
    ima_req_t core_req;
    logic [0:0] core_bank;
    ima_rsp_t core_rsp;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] mem [2][256];
    logic [7:0] ptr0 = IMA_PTR_RST;
    logic [7:0] ptr1 = IMA_PTR_RST;
    logic [7:0] expq [$];
    logic [31:0] rnd = 32'd45942;

    always #5 core_clk = ~core_clk;

    ima_indirect u_dut (.core_clk(core_clk), .arst_n(arst_n), .core_req_valid(core_req_valid),
        .core_req(core_req), .core_bank(core_bank), .core_rsp(core_rsp));
    ima_core_model u_core (.core_clk(core_clk), .core_req_valid(core_req_valid), .core_req(core_req),
        .core_bank(core_bank));

    function automatic logic [7:0] nxt();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[7:0];
    endfunction : nxt

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // Reference: a port aimed at a port behaves like a spare location
    task automatic acc(input logic we, input logic [7:0] a, input logic b, input logic [7:0] d);
        logic [7:0] t;
        logic bk;
        logic ind;
        ind = (a == IMA_PORT_ZERO_ADDR) || (a == IMA_PORT_ONE_ADDR);
        bk = (a == IMA_PORT_ZERO_ADDR) ? 1'b0 : b;
        t = (a == IMA_PORT_ZERO_ADDR) ? ptr0 : (a == IMA_PORT_ONE_ADDR) ? ptr1 : a;
        if (ind && (t == IMA_PORT_ZERO_ADDR || t == IMA_PORT_ONE_ADDR))
            t = 8'h04;
        if (we && t == IMA_PTR_ZERO_ADDR)
            ptr0 = d;
        else if (we && t == IMA_PTR_ONE_ADDR)
            ptr1 = d;
        else if (we && t >= IMA_GP_BASE)
            mem[bk][t] = d;
        else if (!we)
            expq.push_back(t == IMA_PTR_ZERO_ADDR ? ptr0 : t == IMA_PTR_ONE_ADDR ? ptr1 :
                t >= IMA_GP_BASE ? mem[bk][t] : IMA_READ_ZERO);
        u_core.access(we, a, b, d);
    endtask : acc

    ////////////////////////////////////////////////////////////////////////////
    // Watcher: each answer takes the oldest note
    always @(negedge core_clk)
    begin
        cycles++;
        if (core_rsp.valid === 1'b1)
        begin
            checks_done++;
            if (expq.size() == 0 || core_rsp.data !== expq.pop_front())
            begin
                errors++;
                $display("CHECK FAILED %0t unexpected read answer %0h", $time, core_rsp.data);
            end
        end
        if (cycles > 3000)
        begin
            errors++;
            $display("CHECK FAILED %0t run too long", $time);
            report_and_stop();
        end
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        acc(1'b0, IMA_PTR_ZERO_ADDR, 1'b0, 8'h00);
        acc(1'b0, IMA_PTR_ONE_ADDR, 1'b1, 8'h00);
        acc(1'b1, IMA_PTR_ZERO_ADDR, 1'b0, 8'h3C);
        acc(1'b0, IMA_PTR_ZERO_ADDR, 1'b0, 8'h00);
        for (int i = 64; i < 256; i++)
        begin
            acc(1'b1, i[7:0], 1'b0, nxt());
            acc(1'b1, i[7:0], 1'b1, nxt());
        end
        acc(1'b1, IMA_PTR_ZERO_ADDR, 1'b1, 8'h41);
        acc(1'b0, IMA_PORT_ZERO_ADDR, 1'b1, 8'h00);
        acc(1'b1, IMA_PORT_ZERO_ADDR, 1'b1, 8'h5A);
        acc(1'b0, 8'h41, 1'b0, 8'h00);
        acc(1'b0, 8'h41, 1'b1, 8'h00);
        acc(1'b1, IMA_PTR_ONE_ADDR, 1'b0, 8'h80);
        acc(1'b0, IMA_PORT_ONE_ADDR, 1'b1, 8'h00);
        acc(1'b1, IMA_PORT_ONE_ADDR, 1'b1, 8'hC3);
        acc(1'b0, 8'h80, 1'b1, 8'h00);
        acc(1'b0, 8'h80, 1'b0, 8'h00);
        acc(1'b1, IMA_PTR_ZERO_ADDR, 1'b0, IMA_PORT_ONE_ADDR);
        acc(1'b1, IMA_PTR_ONE_ADDR, 1'b0, IMA_PORT_ZERO_ADDR);
        acc(1'b0, IMA_PORT_ZERO_ADDR, 1'b0, 8'h00);
        acc(1'b0, IMA_PORT_ONE_ADDR, 1'b1, 8'h00);
        acc(1'b1, IMA_PORT_ZERO_ADDR, 1'b0, 8'hFF);
        acc(1'b1, IMA_PORT_ONE_ADDR, 1'b1, 8'hEE);
        acc(1'b0, IMA_PORT_ONE_ADDR, 1'b1, 8'h00);
        acc(1'b0, IMA_PTR_ZERO_ADDR, 1'b0, 8'h00);
        acc(1'b0, IMA_PTR_ONE_ADDR, 1'b0, 8'h00);
        acc(1'b1, IMA_PTR_ONE_ADDR, 1'b0, IMA_PTR_ZERO_ADDR);
        acc(1'b1, IMA_PORT_ONE_ADDR, 1'b0, 8'h77);
        acc(1'b0, IMA_PTR_ZERO_ADDR, 1'b0, 8'h00);
        for (int i = 4; i < 64; i += 7)
        begin
            acc(1'b1, i[7:0], i[0], nxt());
            acc(1'b0, i[7:0], i[0], 8'h00);
        end
        repeat (300)
            acc(nxt() > 8'h7F, nxt(), nxt() > 8'h7F, nxt());
        u_core.idle();
        repeat (3) @(negedge core_clk);
        if (expq.size() != 0)
        begin
            errors++;
            $display("CHECK FAILED %0t read answers missing", $time);
        end
        report_and_stop();
    end
endmodule : tb_top
